// ===== rtl/ggrb_regs.v
// Purpose: APB readback bank for pin levels, threshold select and gauge results
// Assumes: Single clock; gauge results arrive as whole words with load strobes
// Notes:   Zero wait states; unmapped addresses read zero with pslverr
//
// Contract
// R1: Local pin levels read in bits 7..4, valid only while comparator enabled.
// R2: Bit 0 of local pin register is read/write input threshold select.
// R3: Remote pin levels read in bits 3..0, clearing to zero at reset.
// R4: Averaged cell voltage readable as 16-bit upper/lower byte pair.
// R5: Averaged value is the gauge's 45 second moving average, passed through.
// R6: Instantaneous cell voltage pair at 0x62 upper, 0x63 lower.
// R7: Time to empty pair at 0x64 upper, 0x65 lower.
// R8: Upper byte at even offset, lower at next; all reset to zero.
// R9: State of charge pair with upper byte at 0x66.
// R10: Read-only reliability flag per quantity for software.
// R11: Both bytes of each pair update together for coherent reads.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "ggrb_map.vh"

module ggrb_regs #(
    parameter NPINS = 4,
    parameter GW    = 16
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    input  wire [3:0]       pstrb,
    output wire             pready,
    output reg  [31:0]      prdata,
    output reg              pslverr,
    // Local pins
    input  wire [NPINS-1:0] local_pin_level,
    input  wire [NPINS-1:0] pin_comparator_enable,
    output wire             input_threshold_select,
    // Remote pins
    input  wire [NPINS-1:0] remote_pin_level,
    // Gauge averaged cell voltage
    input  wire             avg_vcell_load,
    input  wire [GW-1:0]    avg_vcell_value,
    input  wire             avg_vcell_reliable,
    // Gauge instantaneous cell voltage
    input  wire             vcell_load,
    input  wire [GW-1:0]    vcell_value,
    input  wire             vcell_reliable,
    // Gauge time to empty
    input  wire             tte_load,
    input  wire [GW-1:0]    tte_value,
    input  wire             tte_reliable,
    // Gauge state of charge
    input  wire             soc_load,
    input  wire [GW-1:0]    soc_value,
    input  wire             soc_reliable
);

    // ------------------------------------------------------------------------
    // Local declarations
    // ------------------------------------------------------------------------
    reg               thresh_q;
    reg  [31:0]       rdata_d;
    reg               err_d;
    wire [NPINS-1:0]  local_q;
    wire [NPINS-1:0]  remote_q;
    wire [7:0]        avg_hi;
    wire [7:0]        avg_lo;
    wire [7:0]        vc_hi;
    wire [7:0]        vc_lo;
    wire [7:0]        tte_hi;
    wire [7:0]        tte_lo;
    wire [7:0]        soc_hi;
    wire [7:0]        soc_lo;
    wire              avg_rdy;
    wire              vc_rdy;
    wire              tte_rdy;
    wire              soc_rdy;
    wire [9:0]        idx;
    wire              acc;
    wire              wr_en;

    // Word index from byte address
    function [9:0] word_index;
        input [11:0] a;
        begin
            word_index = a[11:`GGRB_ADDR_LSB];
        end
    endfunction

    // Zero-extend a byte to the bus width
    function [31:0] byte_word;
        input [7:0] b;
        begin
            byte_word = {24'h000000, b};
        end
    endfunction

    assign idx    = word_index(paddr);
    assign acc    = psel & penable;
    assign wr_en  = acc & pwrite;
    // Every access completes at once: nothing here needs wait states
    assign pready = 1'b1;

    // ------------------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------------------
    ggrb_pin_sync #(
        .NPINS (NPINS)
    ) u_pins (
        .clk        (clk),
        .rst        (rst),
        .local_lvl  (local_pin_level),
        .cmp_en     (pin_comparator_enable),
        .remote_lvl (remote_pin_level),
        .local_q    (local_q),
        .remote_q   (remote_q)
    );

    // ------------------------------------------------------------------------
    // Gauge pairs
    // ------------------------------------------------------------------------
    // Averaging over the window is done by the gauge; stored as delivered
    ggrb_pair_reg #(.WIDTH(GW)) u_avg (  // [R4] [R5]
        .clk       (clk),
        .rst       (rst),
        .load      (avg_vcell_load),
        .din       (avg_vcell_value),
        .valid_in  (avg_vcell_reliable),
        .hi_byte   (avg_hi),
        .lo_byte   (avg_lo),
        .valid_out (avg_rdy)
    );

    ggrb_pair_reg #(.WIDTH(GW)) u_vcell (  // [R6]
        .clk       (clk),
        .rst       (rst),
        .load      (vcell_load),
        .din       (vcell_value),
        .valid_in  (vcell_reliable),
        .hi_byte   (vc_hi),
        .lo_byte   (vc_lo),
        .valid_out (vc_rdy)
    );

    ggrb_pair_reg #(.WIDTH(GW)) u_tte (  // [R7]
        .clk       (clk),
        .rst       (rst),
        .load      (tte_load),
        .din       (tte_value),
        .valid_in  (tte_reliable),
        .hi_byte   (tte_hi),
        .lo_byte   (tte_lo),
        .valid_out (tte_rdy)
    );

    ggrb_pair_reg #(.WIDTH(GW)) u_soc (  // [R9]
        .clk       (clk),
        .rst       (rst),
        .load      (soc_load),
        .din       (soc_value),
        .valid_in  (soc_reliable),
        .hi_byte   (soc_hi),
        .lo_byte   (soc_lo),
        .valid_out (soc_rdy)
    );

    // ------------------------------------------------------------------------
    // Threshold select, the only writable bit
    // ------------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            thresh_q <= `GGRB_RST_THRESH;
        end else if (wr_en && idx == {2'b00, `GGRB_IDX_LOCAL_PINS} && pstrb[0]) begin
            thresh_q <= pwdata[`GGRB_THRESH_BIT];  // [R2]
        end
    end

    assign input_threshold_select = thresh_q;  // [R2]

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------
    always @* begin
        rdata_d = `GGRB_ZERO_WORD;
        err_d   = 1'b0;
        if (idx == {2'b00, `GGRB_IDX_LOCAL_PINS}) begin
            rdata_d[`GGRB_LOCAL_LVL_MSB:`GGRB_LOCAL_LVL_LSB] = local_q;  // [R1]
            rdata_d[`GGRB_THRESH_BIT] = thresh_q;                         // [R2]
        end else if (idx == {2'b00, `GGRB_IDX_REMOTE_PINS}) begin
            rdata_d[`GGRB_REMOTE_LVL_MSB:`GGRB_REMOTE_LVL_LSB] = remote_q;  // [R3]
        end else if (idx == {2'b00, `GGRB_IDX_AVG_VCELL_HI}) begin
            rdata_d = byte_word(avg_hi);  // [R4] [R8]
        end else if (idx == {2'b00, `GGRB_IDX_AVG_VCELL_LO}) begin
            rdata_d = byte_word(avg_lo);  // [R4] [R8]
        end else if (idx == {2'b00, `GGRB_IDX_VCELL_HI}) begin
            rdata_d = byte_word(vc_hi);   // [R6]
        end else if (idx == {2'b00, `GGRB_IDX_VCELL_LO}) begin
            rdata_d = byte_word(vc_lo);   // [R6]
        end else if (idx == {2'b00, `GGRB_IDX_TTE_HI}) begin
            rdata_d = byte_word(tte_hi);  // [R7]
        end else if (idx == {2'b00, `GGRB_IDX_TTE_LO}) begin
            rdata_d = byte_word(tte_lo);  // [R7]
        end else if (idx == {2'b00, `GGRB_IDX_SOC_HI}) begin
            rdata_d = byte_word(soc_hi);  // [R9]
        end else if (idx == {2'b00, `GGRB_IDX_SOC_LO}) begin
            rdata_d = byte_word(soc_lo);  // [R9]
        end else if (idx == {2'b00, `GGRB_IDX_READY}) begin
            rdata_d[`GGRB_RDY_AVG_BIT]   = avg_rdy;  // [R10]
            rdata_d[`GGRB_RDY_VCELL_BIT] = vc_rdy;   // [R10]
            rdata_d[`GGRB_RDY_TTE_BIT]   = tte_rdy;  // [R10]
            rdata_d[`GGRB_RDY_SOC_BIT]   = soc_rdy;  // [R10]
        end else begin
            err_d = 1'b1;
        end
    end

    // Data registered in the setup cycle so the access phase sees it stable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata  <= `GGRB_ZERO_WORD;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? `GGRB_ZERO_WORD : rdata_d;
            pslverr <= err_d;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

endmodule // ggrb_regs

// ===== shared/ggrb_map.vh
// Purpose: Register offsets, field positions and reset values of the readback bank
// Assumes: APB byte address = 4 x printed register index
// Notes:   Included by all design files
`ifndef GGRB_MAP_VH
`define GGRB_MAP_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------------------
`define GGRB_IDX_LOCAL_PINS    8'h5C
`define GGRB_IDX_REMOTE_PINS   8'h5D
`define GGRB_IDX_AVG_VCELL_HI  8'h60
`define GGRB_IDX_AVG_VCELL_LO  8'h61
`define GGRB_IDX_VCELL_HI      8'h62
`define GGRB_IDX_VCELL_LO      8'h63
`define GGRB_IDX_TTE_HI        8'h64
`define GGRB_IDX_TTE_LO        8'h65
`define GGRB_IDX_SOC_HI        8'h66
`define GGRB_IDX_SOC_LO        8'h67
`define GGRB_IDX_READY         8'h6A

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GGRB_LOCAL_LVL_MSB     7
`define GGRB_LOCAL_LVL_LSB     4
`define GGRB_THRESH_BIT        0
`define GGRB_REMOTE_LVL_MSB    3
`define GGRB_REMOTE_LVL_LSB    0
`define GGRB_RDY_AVG_BIT       0
`define GGRB_RDY_VCELL_BIT     1
`define GGRB_RDY_TTE_BIT       2
`define GGRB_RDY_SOC_BIT       3

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define GGRB_RST_BYTE          8'h00
`define GGRB_RST_WORD          16'h0000
`define GGRB_RST_NIB           4'h0
`define GGRB_RST_THRESH        1'b0
`define GGRB_ADDR_LSB          2
`define GGRB_ZERO_WORD         32'h0000_0000

`endif

// ===== rtl/ggrb_pair_reg.v
// Purpose: One 16-bit gauge quantity held as an upper/lower byte pair
// Assumes: Gauge presents a full word with a one-cycle load strobe
// Notes:   Both bytes load on the same edge so a pair read stays coherent
`timescale 1ns/1ns
`include "ggrb_map.vh"

module ggrb_pair_reg #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Gauge side
    input  wire             load,
    input  wire [WIDTH-1:0] din,
    input  wire             valid_in,
    // Readback side
    output wire [7:0]       hi_byte,
    output wire [7:0]       lo_byte,
    output wire             valid_out
);

    reg [WIDTH-1:0] word_q;
    reg             valid_q;

    // ------------------------------------------------------------------------
    // Word capture
    // ------------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            word_q  <= `GGRB_RST_WORD;  // [R8]
            valid_q <= 1'b0;
        end else begin
            if (load) begin
                word_q <= din;          // [R11]
            end
            valid_q <= valid_in;        // [R10]
        end
    end

    // Upper byte at the even offset, lower at the odd one
    assign hi_byte   = word_q[WIDTH-1:WIDTH-8];  // [R8]
    assign lo_byte   = word_q[7:0];              // [R8]
    assign valid_out = valid_q;

endmodule // ggrb_pair_reg

// ===== rtl/ggrb_pin_sync.v
// Purpose: Registers the local and remote pin levels for readback
// Assumes: Inputs already synchronous to clk
// Notes:   A local level with its comparator off reads low
`timescale 1ns/1ns
`include "ggrb_map.vh"

module ggrb_pin_sync #(
    parameter NPINS = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Pin levels
    input  wire [NPINS-1:0] local_lvl,
    input  wire [NPINS-1:0] cmp_en,
    input  wire [NPINS-1:0] remote_lvl,
    // Registered levels
    output reg  [NPINS-1:0] local_q,
    output reg  [NPINS-1:0] remote_q
);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            local_q  <= `GGRB_RST_NIB;
            remote_q <= `GGRB_RST_NIB;      // [R3]
        end else begin
            // Masked so a disabled comparator never shows a stale level
            local_q  <= local_lvl & cmp_en; // [R1]
            remote_q <= remote_lvl;         // [R3]
        end
    end

endmodule // ggrb_pin_sync

// ===== dv/ggrb_regs_monitor.sv
// Purpose: Port-level checks on the readback bank
// Assumes: One clock, asynchronous active-high reset
// Notes:   Read data lands on the edge that ends the setup cycle
`timescale 1ns/1ns
`include "ggrb_map.vh"

module ggrb_regs_monitor #(
    parameter NPINS = 4,
    parameter GW    = 16
) (
    // Clock and reset
    input wire             clk,
    input wire             rst,
    // APB
    input wire             psel,
    input wire             penable,
    input wire             pwrite,
    input wire [11:0]      paddr,
    input wire [31:0]      pwdata,
    input wire [3:0]       pstrb,
    input wire [31:0]      prdata,
    // Pins
    input wire [NPINS-1:0] local_pin_level,
    input wire [NPINS-1:0] pin_comparator_enable,
    input wire             input_threshold_select,
    input wire [NPINS-1:0] remote_pin_level,
    // Gauge
    input wire             avg_vcell_load,
    input wire [GW-1:0]    avg_vcell_value,
    input wire             avg_vcell_reliable,
    input wire             vcell_reliable,
    input wire             tte_reliable,
    input wire             soc_reliable
);
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    localparam [11:0] A_LOC = {2'b00, `GGRB_IDX_LOCAL_PINS, 2'b00};
    localparam [11:0] A_REM = {2'b00, `GGRB_IDX_REMOTE_PINS, 2'b00};
    localparam [11:0] A_AVH = {2'b00, `GGRB_IDX_AVG_VCELL_HI, 2'b00};
    localparam [11:0] A_AVL = {2'b00, `GGRB_IDX_AVG_VCELL_LO, 2'b00};
    localparam [11:0] A_RDY = {2'b00, `GGRB_IDX_READY, 2'b00};
    reg  [GW-1:0]    avg_q;
    wire             rd    = psel && !penable && !pwrite;
    wire             wd0   = pwdata[0];
    wire [7:0]       avg_h = avg_q[15:8];
    wire [7:0]       avg_l = avg_q[7:0];
    wire [NPINS-1:0] loc_m = local_pin_level & pin_comparator_enable;
    wire [3:0]       rdy   = {soc_reliable, tte_reliable, vcell_reliable, avg_vcell_reliable};
    // Shadow of the last averaged cell voltage word, so reads of its pair can be judged
    always @(posedge clk or posedge rst) begin
        if (rst)
            avg_q <= 16'h0000;
        else if (avg_vcell_load)
            avg_q <= avg_vcell_value;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_remote_levels: assert property (rd && paddr == A_REM |=>
        prdata[3:0] == $past(remote_pin_level, 2)) else $error("remote levels wrong");
    a_local_masked: assert property (rd && paddr == A_LOC |=>
        prdata[7:4] == $past(loc_m, 2)) else $error("local levels wrong");
    a_thresh_read: assert property (rd && paddr == A_LOC |=>
        prdata[3:0] == {3'b000, input_threshold_select}) else $error("threshold read wrong");
    a_thresh_write: assert property (psel && penable && pwrite && pstrb[0] && paddr == A_LOC
        |=> input_threshold_select == $past(wd0)) else $error("threshold write lost");
    a_thresh_hold: assert property (!(psel && penable && pwrite)
        |=> $stable(input_threshold_select)) else $error("threshold changed");
    a_ready_flags: assert property (rd && paddr == A_RDY |=>
        prdata[3:0] == $past(rdy, 2)) else $error("ready flags wrong");
    a_upper_zero: assert property (rd |=> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_avg_high: assert property (rd && paddr == A_AVH |=>
        prdata[7:0] == $past(avg_h)) else $error("average upper byte wrong");
    a_avg_low: assert property (rd && paddr == A_AVL |=>
        prdata[7:0] == $past(avg_l)) else $error("average lower byte wrong");
endmodule // ggrb_regs_monitor

bind ggrb_regs ggrb_regs_monitor #(.NPINS(NPINS), .GW(GW)) u_mon (.*);

// ===== dv/tb_gpio_and_gauge_readback_regs.sv
// Purpose: Directed APB tests of the readback bank
// Assumes: Master waits for pready; read data of writes is zero
// Notes:   One load strobe drives all four gauge words
`timescale 1ns/1ns
`include "ggrb_map.vh"

module tb_gpio_and_gauge_readback_regs;
    reg         clk, rst, psel, penable, pwrite, ld;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [3:0]  pstrb, lvl, cen, rlv, rel;
    reg  [15:0] gv [0:3];
    reg  [7:0]  off;
    wire        pready, pslverr, thr;
    wire [31:0] prdata;
    integer     n_errors, samples_checked, i;

    ggrb_regs DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .local_pin_level(lvl), .pin_comparator_enable(cen),
        .input_threshold_select(thr), .remote_pin_level(rlv),
        .avg_vcell_load(ld), .avg_vcell_value(gv[0]), .avg_vcell_reliable(rel[0]),
        .vcell_load(ld), .vcell_value(gv[1]), .vcell_reliable(rel[1]),
        .tte_load(ld), .tte_value(gv[2]), .tte_reliable(rel[2]),
        .soc_load(ld), .soc_value(gv[3]), .soc_reliable(rel[3]));

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== ex) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    // Holds the request until pready is seen high at an edge
    // Only the watchdog ends a wait that never sees pready
    task apb(input w, input [7:0] idx, input [31:0] wd, input [31:0] ex, input er);
        begin
            psel <= 1'b1; penable <= 1'b0; pwrite <= w;
            paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) begin
                @(posedge clk);
            end
            chk("prdata", ex, prdata);
            chk("pslverr", {31'h0, er}, {31'h0, pslverr});
            psel <= 1'b0; penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task settle;
        repeat (2) @(posedge clk);
    endtask
    task gload;
        begin
            ld <= 1'b1;
            @(posedge clk);
            ld <= 1'b0;
            @(posedge clk);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // ------------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        n_errors = n_errors + 1;
        final_report;
    end
    initial begin
        n_errors = 0; samples_checked = 0;
        rst <= 1'b1; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0; ld <= 1'b0;
        paddr <= 12'h000; pwdata <= 32'h0; pstrb <= 4'hF;
        lvl <= 4'hF; cen <= 4'h0; rlv <= 4'h0; rel <= 4'h0;
        gv[0] <= 16'h1234; gv[1] <= 16'hABCD; gv[2] <= 16'hFFFF; gv[3] <= 16'h8001;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle;
        for (i = 0; i < 10; i = i + 1)
            apb(1'b0, (i < 2) ? 8'h5C + i[7:0] : 8'h5E + i[7:0], 32'h0, 32'h0, 1'b0);
        apb(1'b0, `GGRB_IDX_READY, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h5E, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `GGRB_IDX_LOCAL_PINS, 32'h1, 32'h0, 1'b0);
        chk("threshold", 32'h1, {31'h0, thr});
        // A write without byte lane 0 must leave the threshold alone
        pstrb <= 4'hE;
        apb(1'b1, `GGRB_IDX_LOCAL_PINS, 32'h0, 32'h0, 1'b0);
        chk("threshold", 32'h1, {31'h0, thr});
        pstrb <= 4'hF;
        apb(1'b1, 8'h5E, 32'h1, 32'h0, 1'b1);
        apb(1'b1, `GGRB_IDX_AVG_VCELL_HI, 32'hFF, 32'h0, 1'b0);
        apb(1'b0, `GGRB_IDX_AVG_VCELL_HI, 32'h0, 32'h0, 1'b0);
        cen <= 4'hF; lvl <= 4'hA; settle;
        apb(1'b0, `GGRB_IDX_LOCAL_PINS, 32'h0, 32'hA1, 1'b0);
        cen <= 4'h3; settle;
        apb(1'b0, `GGRB_IDX_LOCAL_PINS, 32'h0, 32'h21, 1'b0);
        rlv <= 4'h9; settle;
        apb(1'b0, `GGRB_IDX_REMOTE_PINS, 32'h0, 32'h9, 1'b0);
        gload;
        for (i = 0; i < 4; i = i + 1) begin
            off = {i[6:0], 1'b0};
            apb(1'b0, 8'h60 + off, 32'h0, {24'h0, gv[i][15:8]}, 1'b0);
            apb(1'b0, 8'h61 + off, 32'h0, {24'h0, gv[i][7:0]}, 1'b0);
        end
        rel <= 4'h5; settle;
        apb(1'b0, `GGRB_IDX_READY, 32'h0, 32'h5, 1'b0);
        rel <= 4'hA; settle;
        apb(1'b0, `GGRB_IDX_READY, 32'h0, 32'hA, 1'b0);
        gv[0] <= 16'h00FF;
        gload;
        apb(1'b0, `GGRB_IDX_AVG_VCELL_HI, 32'h0, 32'h00, 1'b0);
        apb(1'b0, `GGRB_IDX_AVG_VCELL_LO, 32'h0, 32'hFF, 1'b0);
        // A second reset mid-run must clear the threshold and gauge words
        rst <= 1'b1;
        @(posedge clk);
        chk("threshold", 32'h0, {31'h0, thr});
        rst <= 1'b0;
        settle;
        apb(1'b0, `GGRB_IDX_VCELL_HI, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `GGRB_IDX_LOCAL_PINS, 32'h0, 32'h20, 1'b0);
        final_report;
    end
endmodule // tb_gpio_and_gauge_readback_regs
